// ==== verilog/sfl_unit.sv ====
// String and floating-point load/store execution unit
`timescale 1ns/1ps
module sfl_unit (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic little_endian, // Core byte order is little-endian
    input wire logic float_unit_present, // Variant has a float unit
    input wire logic req_valid, // Dispatch request valid
    input wire sfl_pkg::sfl_req_t req, // Dispatch request
    output logic req_ready, // Unit idle and can accept
    output logic gpr_rd_en, // Read request for a store string source
    output logic [4:0] gpr_rd_index, // Source register index
    input wire logic [31:0] gpr_rd_data, // Source register data, same cycle
    output logic xlat_valid, // Translation request
    output logic [31:0] xlat_addr, // Address to translate
    input wire logic xlat_done, // Translation answer valid
    input wire logic xlat_fault, // Page fault
    input wire logic xlat_direct_store, // Segment is direct-store
    output logic mem_valid, // Memory access valid
    output sfl_pkg::sfl_mem_t mem, // Memory access
    input wire logic mem_done, // Access complete
    input wire logic [63:0] mem_rdata, // Load data, right aligned
    output logic wb_valid, // Register write-back pulse
    output sfl_pkg::sfl_wb_t wb, // Write-back payload
    output logic done, // Instruction finished pulse
    output sfl_pkg::sfl_exc_t exc // Exception with done
);
    typedef enum logic [2:0] {ST_IDLE, ST_XLAT, ST_ACCESS, ST_UPDATE, ST_FINISH} sfl_state_t;

    sfl_state_t state_ff, nxt_state;
    sfl_pkg::sfl_req_t req_ff, nxt_req;
    logic [31:0] ea_ff, nxt_ea;
    logic [31:0] page_ff, nxt_page;
    logic page_ok_ff, nxt_page_ok;
    logic [6:0] left_ff, nxt_left;
    logic [1:0] lane_ff, nxt_lane;
    logic [4:0] reg_ff, nxt_reg;
    logic [31:0] accum_ff, nxt_accum;
    sfl_pkg::sfl_exc_t exc_ff, nxt_exc;
    logic done_ff, nxt_done;
    logic wb_valid_ff, nxt_wb_valid;
    sfl_pkg::sfl_wb_t wb_ff, nxt_wb;

    logic is_string;
    logic is_float;
    logic [31:0] ea_calc;
    logic [6:0] count_calc;
    logic [63:0] widened;
    logic [31:0] narrowed;
    logic [31:0] src_word;
    logic [7:0] src_byte;
    logic [31:0] merged;
    logic [31:0] ea_next;
    logic new_page;

    sfl_fp_convert u_conv (
        .single_in(mem_rdata[31:0]),
        .double_in(req_ff.float_value),
        .double_out(widened),
        .single_out(narrowed)
    );

    always_comb
    begin
        is_string = (req.op == sfl_pkg::SFL_OP_STR_LOAD) || (req.op == sfl_pkg::SFL_OP_STR_STORE);
        is_float = !is_string;
        // Indexed forms add index register, else sign-extended displacement
        if (req.indexed)
            ea_calc = req.base_value + req.index_value;
        else
            ea_calc = req.base_value + {{16{req.displacement[15]}}, req.displacement};
        // Immediate count 0 means 32; indexed count 0 is a valid no-op
        if (req.indexed)
            count_calc = req.xer_count;
        else if (req.byte_count_field == 7'h00)
            count_calc = sfl_pkg::MAX_BYTES;
        else
            count_calc = req.byte_count_field;
    end

    assign req_ready = (state_ff == ST_IDLE);
    assign ea_next = ea_ff + 32'h00000001;
    // Each byte goes alone, so alignment never matters, only cycle count
    assign new_page = ((ea_ff & sfl_pkg::PAGE_MASK) != page_ff) || !page_ok_ff;
    assign gpr_rd_en = (state_ff == ST_ACCESS) && (req_ff.op == sfl_pkg::SFL_OP_STR_STORE) && !new_page;
    assign gpr_rd_index = reg_ff;
    assign src_word = gpr_rd_data;

    always_comb
    begin
        unique case (lane_ff)
            2'h0: src_byte = src_word[31:24];
            2'h1: src_byte = src_word[23:16];
            2'h2: src_byte = src_word[15:8];
            default: src_byte = src_word[7:0];
        endcase
        merged = accum_ff;
        unique case (lane_ff)
            2'h0: merged[31:24] = mem_rdata[7:0];
            2'h1: merged[23:16] = mem_rdata[7:0];
            2'h2: merged[15:8] = mem_rdata[7:0];
            default: merged[7:0] = mem_rdata[7:0];
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_ea = ea_ff;
        nxt_page = page_ff;
        nxt_page_ok = page_ok_ff;
        nxt_left = left_ff;
        nxt_lane = lane_ff;
        nxt_reg = reg_ff;
        nxt_accum = accum_ff;
        nxt_exc = exc_ff;
        nxt_done = 1'b0;
        nxt_wb_valid = 1'b0;
        nxt_wb = wb_ff;
        xlat_valid = 1'b0;
        xlat_addr = ea_ff;
        mem_valid = 1'b0;
        mem = '0;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    // Every start is from byte zero, so a restart after a fault replays all
                    nxt_req = req;
                    nxt_ea = ea_calc;
                    nxt_left = count_calc;
                    nxt_lane = 2'h0;
                    nxt_reg = req.target_register;
                    nxt_accum = 32'h00000000;
                    nxt_page_ok = 1'b0;
                    nxt_exc = sfl_pkg::SFL_EXC_NONE;
                    // Base/index overlap with targets is not checked: valid forms
                    if (is_string && little_endian)
                    begin
                        nxt_exc = sfl_pkg::SFL_EXC_ALIGN;
                        nxt_state = ST_FINISH;
                    end
                    else if (is_float && !float_unit_present)
                    begin
                        nxt_exc = sfl_pkg::SFL_EXC_ILLEGAL;
                        nxt_state = ST_FINISH;
                    end
                    else if (is_string && count_calc == 7'h00)
                        nxt_state = ST_FINISH;
                    else
                        nxt_state = is_string ? ST_ACCESS : ST_XLAT;
                end
            end
            ST_XLAT:
            begin
                xlat_valid = 1'b1;
                if (xlat_done)
                begin
                    if (xlat_fault || (!req_ff.op[2] && req_ff.op[1] && xlat_direct_store) ||
                        (req_ff.op == sfl_pkg::SFL_OP_FP_STORE_INT && xlat_direct_store))
                    begin
                        nxt_exc = sfl_pkg::SFL_EXC_STORAGE;
                        nxt_state = ST_FINISH;
                    end
                    else
                    begin
                        nxt_page = ea_ff & sfl_pkg::PAGE_MASK;
                        nxt_page_ok = 1'b1;
                        nxt_state = ST_ACCESS;
                    end
                end
            end
            ST_ACCESS:
            begin
                if (req_ff.op == sfl_pkg::SFL_OP_STR_LOAD || req_ff.op == sfl_pkg::SFL_OP_STR_STORE)
                begin
                    if (new_page)
                        nxt_state = ST_XLAT;
                    else
                    begin
                        mem_valid = 1'b1;
                        mem.write = (req_ff.op == sfl_pkg::SFL_OP_STR_STORE);
                        mem.effective_address = ea_ff;
                        mem.size_m1 = 3'h0;
                        mem.wdata = {56'h0, src_byte};
                        if (mem_done)
                        begin
                            nxt_ea = ea_next;
                            nxt_left = left_ff - 7'h01;
                            nxt_lane = lane_ff + 2'h1;
                            if (req_ff.op == sfl_pkg::SFL_OP_STR_LOAD)
                            begin
                                nxt_accum = merged;
                                // Register completes at lane 3 or last byte, pad is zero
                                if (lane_ff == sfl_pkg::WORD_OFS_MASK || left_ff == 7'h01)
                                begin
                                    nxt_wb_valid = 1'b1;
                                    nxt_wb = '{float_dest: 1'b0, index: reg_ff, value: {32'h0, merged}};
                                    nxt_accum = 32'h00000000;
                                end
                            end
                            if (lane_ff == sfl_pkg::WORD_OFS_MASK)
                                nxt_reg = reg_ff + 5'h01;
                            if (left_ff == 7'h01)
                                nxt_state = ST_FINISH;
                        end
                    end
                end
                else
                begin
                    mem_valid = 1'b1;
                    mem.write = (req_ff.op != sfl_pkg::SFL_OP_FP_LOAD);
                    mem.effective_address = ea_ff;
                    mem.size_m1 = (req_ff.single || req_ff.op == sfl_pkg::SFL_OP_FP_STORE_INT) ? 3'h3 : 3'h7;
                    if (req_ff.op == sfl_pkg::SFL_OP_FP_STORE_INT)
                        mem.wdata = {32'h0, req_ff.float_value[31:0]};
                    else if (req_ff.single)
                        mem.wdata = {32'h0, narrowed};
                    else
                        mem.wdata = req_ff.float_value;
                    if (mem_done)
                    begin
                        if (req_ff.op == sfl_pkg::SFL_OP_FP_LOAD)
                        begin
                            nxt_wb_valid = 1'b1;
                            nxt_wb = '{float_dest: 1'b1, index: req_ff.target_register,
                                value: req_ff.single ? widened : mem_rdata};
                        end
                        // Base zero update forms run as valid forms
                        nxt_state = req_ff.update ? ST_UPDATE : ST_FINISH;
                    end
                end
            end
            ST_UPDATE:
            begin
                if (req_ff.base_register != 5'h00)
                begin
                    nxt_wb_valid = 1'b1;
                    nxt_wb = '{float_dest: 1'b0, index: req_ff.base_register, value: {32'h0, ea_ff}};
                end
                nxt_state = ST_FINISH;
            end
            ST_FINISH:
            begin
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            ea_ff <= 32'h00000000;
            page_ff <= 32'h00000000;
            page_ok_ff <= 1'b0;
            left_ff <= 7'h00;
            lane_ff <= 2'h0;
            reg_ff <= 5'h00;
            accum_ff <= 32'h00000000;
            exc_ff <= sfl_pkg::SFL_EXC_NONE;
            done_ff <= 1'b0;
            wb_valid_ff <= 1'b0;
            wb_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            ea_ff <= nxt_ea;
            page_ff <= nxt_page;
            page_ok_ff <= nxt_page_ok;
            left_ff <= nxt_left;
            lane_ff <= nxt_lane;
            reg_ff <= nxt_reg;
            accum_ff <= nxt_accum;
            exc_ff <= nxt_exc;
            done_ff <= nxt_done;
            wb_valid_ff <= nxt_wb_valid;
            wb_ff <= nxt_wb;
        end
    end

    assign done = done_ff;
    assign exc = done_ff ? exc_ff : sfl_pkg::SFL_EXC_NONE;
    assign wb_valid = wb_valid_ff;
    assign wb = wb_ff;

    sequence s_le_string;
        req_valid && req_ready && little_endian &&
            (req.op == sfl_pkg::SFL_OP_STR_LOAD || req.op == sfl_pkg::SFL_OP_STR_STORE);
    endsequence

    sequence s_align_done;
        !mem_valid ##1 done && exc == sfl_pkg::SFL_EXC_ALIGN;
    endsequence

    a_le_string_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_le_string |=> s_align_done) else $error("little-endian string not trapped");

    a_nofpu_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (req_valid && req_ready && !float_unit_present && req.op[1]) |=> ##1 done && exc == sfl_pkg::SFL_EXC_ILLEGAL)
        else $error("float op ran without float unit");

    a_fault_storage: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (xlat_valid && xlat_done && xlat_fault) |=> ##1 done && exc == sfl_pkg::SFL_EXC_STORAGE)
        else $error("translation fault not reported");

    a_no_unxlat_access: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (xlat_valid && xlat_done && xlat_fault) |=> !mem_valid[*2]) else $error("access after fault");

    a_direct_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (xlat_valid && xlat_done && xlat_direct_store && req_ff.op[1]) |=> !mem_valid ##1 exc == sfl_pkg::SFL_EXC_STORAGE)
        else $error("float direct-store not trapped");

    a_update_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ST_UPDATE && req_ff.base_register != 5'h00) |=> wb_valid && wb.index == $past(req_ff.base_register)
        && wb.value[31:0] == $past(ea_ff)) else $error("update address not written");

    a_count_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (req_valid && req_ready && req.indexed && req.xer_count == 7'h00 && !little_endian &&
        req.op == sfl_pkg::SFL_OP_STR_LOAD) |=> ##1 done && exc == sfl_pkg::SFL_EXC_NONE)
        else $error("zero count string not accepted");

    a_string_bytes: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mem_valid && state_ff == ST_ACCESS && req_ff.op <= sfl_pkg::SFL_OP_STR_STORE) |->
        mem.size_m1 == 3'h0 && mem.effective_address == ea_ff)
        else $error("string access not byte wide");

    a_int_word_raw: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mem_valid && req_ff.op == sfl_pkg::SFL_OP_FP_STORE_INT) |-> mem.wdata[31:0] == req_ff.float_value[31:0])
        else $error("integer word store converted");

    a_page_access: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mem_valid |-> page_ok_ff && (mem.effective_address & sfl_pkg::PAGE_MASK) == page_ff)
        else $error("access off page");

    a_reg_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mem_valid && mem_done && lane_ff == sfl_pkg::WORD_OFS_MASK) |=> reg_ff == $past(reg_ff) + 5'h01)
        else $error("register not stepped");
endmodule

// ==== verilog/sfl_pkg.sv ====
// Shared types and constants for the string and floating-point load/store unit
package sfl_pkg;
    localparam int unsigned REG_IDX_W = 5;
    localparam int unsigned COUNT_W = 7;
    localparam logic [COUNT_W-1:0] MAX_BYTES = 7'h20;
    localparam logic [31:0] PAGE_MASK = 32'hFFFFF000;
    localparam logic [1:0] WORD_OFS_MASK = 2'h3;
    localparam logic [2:0] BYTES_PER_REG = 3'h4;
    localparam logic [10:0] EXP_BIAS_DIFF = 11'h380;

    typedef enum logic [2:0] {
        SFL_OP_STR_LOAD,
        SFL_OP_STR_STORE,
        SFL_OP_FP_LOAD,
        SFL_OP_FP_STORE,
        SFL_OP_FP_STORE_INT
    } sfl_op_t;

    typedef enum logic [1:0] {
        SFL_EXC_NONE,
        SFL_EXC_ALIGN,
        SFL_EXC_STORAGE,
        SFL_EXC_ILLEGAL
    } sfl_exc_t;

    // Dispatched request
    typedef struct packed {
        sfl_op_t op;
        logic indexed;
        logic update;
        logic single;
        logic [REG_IDX_W-1:0] target_register;
        logic [REG_IDX_W-1:0] base_register;
        logic [REG_IDX_W-1:0] index_register;
        logic [15:0] displacement;
        logic [COUNT_W-1:0] byte_count_field;
        logic [31:0] base_value;
        logic [31:0] index_value;
        logic [63:0] float_value;
        logic [6:0] xer_count;
    } sfl_req_t;

    // Memory access of one to eight bytes toward the cache path
    typedef struct packed {
        logic write;
        logic [31:0] effective_address;
        logic [2:0] size_m1;
        logic [63:0] wdata;
    } sfl_mem_t;

    // Register write-back
    typedef struct packed {
        logic float_dest;
        logic [REG_IDX_W-1:0] index;
        logic [63:0] value;
    } sfl_wb_t;
endpackage

// ==== verilog/sfl_fp_convert.sv ====
// Single/double precision format conversion
`timescale 1ns/1ps
module sfl_fp_convert (
    input wire logic [31:0] single_in, // Single-precision bits
    input wire logic [63:0] double_in, // Double-precision bits
    output logic [63:0] double_out, // Widened value
    output logic [31:0] single_out // Narrowed value
);
    logic [7:0] s_exp;
    logic [10:0] d_exp;
    always_comb
    begin
        s_exp = single_in[30:23];
        // Widen: zero stays zero, max exponent stays max, else rebias
        if (s_exp == 8'h00)
            double_out = {single_in[31], 11'h000, single_in[22:0], 29'h00000000};
        else if (s_exp == 8'hFF)
            double_out = {single_in[31], 11'h7FF, single_in[22:0], 29'h00000000};
        else
            double_out = {single_in[31], {3'h0, s_exp} + sfl_pkg::EXP_BIAS_DIFF,
                single_in[22:0], 29'h00000000};
        d_exp = double_in[62:52];
        // Narrow: exponent bits keep top and low seven, fraction truncated
        single_out = {double_in[63], d_exp[10], d_exp[6:0], double_in[51:29]};
    end
endmodule

// ==== test/sfl_mem_model.sv ====
// Translation and data cache stand-in facing the load/store unit
`timescale 1ns/1ps
module sfl_mem_model (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic slow, // Answer after three extra wait cycles
    input wire logic [31:0] fault_page, // Page that faults, zero for none
    input wire logic [31:0] ds_page, // Direct-store page, zero for none
    input wire logic xlat_valid, // Translation request
    input wire logic [31:0] xlat_addr, // Address to translate
    output logic xlat_done, // Translation answer
    output logic xlat_fault, // Page fault
    output logic xlat_direct_store, // Direct-store segment
    input wire logic mem_valid, // Access request
    input wire sfl_pkg::sfl_mem_t mem, // Access
    output logic mem_done, // Access complete
    output logic [63:0] mem_rdata // Read data, right aligned
);
    logic [7:0] mem_b [logic [31:0]];
    logic [1:0] xw_ff;
    logic [1:0] mw_ff;
    logic [1:0] lat;
    function automatic logic [7:0] rd8(input logic [31:0] a);
        return mem_b.exists(a) ? mem_b[a] : a[7:0] ^ 8'hA5;
    endfunction
    function automatic logic [63:0] rdn(input logic [31:0] a, input logic [2:0] m);
        logic [63:0] v;
        v = '0;
        for (int i = 0; i <= 7; i++)
            if (i <= m)
                v = {v[55:0], rd8(a + i)};
        return v;
    endfunction
    assign lat = slow ? 2'h3 : 2'h0;
    assign xlat_fault = xlat_done && fault_page != 0 && (xlat_addr & sfl_pkg::PAGE_MASK) == fault_page;
    assign xlat_direct_store = xlat_done && ds_page != 0 && (xlat_addr & sfl_pkg::PAGE_MASK) == ds_page;
    // Released data lines show the inverse, never the last value
    assign mem_rdata = mem_done ? rdn(mem.effective_address, mem.size_m1) : ~rdn(mem.effective_address, 3'h7);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xw_ff <= 2'h0;
            mw_ff <= 2'h0;
            xlat_done <= 1'b0;
            mem_done <= 1'b0;
        end
        else
        begin
            xlat_done <= xlat_valid && !xlat_done && xw_ff == lat;
            xw_ff <= (xlat_valid && !xlat_done) ? xw_ff + 2'h1 : 2'h0;
            mem_done <= mem_valid && !mem_done && mw_ff == lat;
            mw_ff <= (mem_valid && !mem_done) ? mw_ff + 2'h1 : 2'h0;
        end
    end
    always @(posedge sys_clk)
        if (mem_valid && mem_done && mem.write)
            for (int i = 0; i <= 7; i++)
                if (i <= mem.size_m1)
                    mem_b[mem.effective_address + i] = mem.wdata[8 * (mem.size_m1 - i) +: 8];
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the string and float load/store unit
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic little_endian = 1'b0;
    logic float_unit = 1'b1;
    logic slow = 1'b0;
    logic req_valid = 1'b0;
    logic [31:0] fault_page = '0;
    logic [31:0] ds_page = '0;
    sfl_pkg::sfl_req_t req = '0;
    logic req_ready, gpr_rd_en, xlat_valid, xlat_done, xlat_fault, xlat_ds, mem_valid, mem_done, wb_valid, done;
    logic [4:0] gpr_rd_index;
    logic [31:0] gpr_rd_data, xlat_addr;
    logic [63:0] mem_rdata;
    sfl_pkg::sfl_mem_t mem;
    sfl_pkg::sfl_wb_t wb;
    sfl_pkg::sfl_exc_t exc, last_exc;
    sfl_pkg::sfl_mem_t mq[$];
    sfl_pkg::sfl_wb_t wq[$];
    logic got_done = 1'b0;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    sfl_unit u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .little_endian(little_endian), .float_unit_present(float_unit),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .gpr_rd_en(gpr_rd_en),
        .gpr_rd_index(gpr_rd_index), .gpr_rd_data(gpr_rd_data), .xlat_valid(xlat_valid), .xlat_addr(xlat_addr),
        .xlat_done(xlat_done), .xlat_fault(xlat_fault), .xlat_direct_store(xlat_ds), .mem_valid(mem_valid),
        .mem(mem), .mem_done(mem_done), .mem_rdata(mem_rdata), .wb_valid(wb_valid), .wb(wb), .done(done), .exc(exc));
    sfl_mem_model u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .fault_page(fault_page), .ds_page(ds_page),
        .xlat_valid(xlat_valid), .xlat_addr(xlat_addr), .xlat_done(xlat_done), .xlat_fault(xlat_fault),
        .xlat_direct_store(xlat_ds), .mem_valid(mem_valid), .mem(mem), .mem_done(mem_done), .mem_rdata(mem_rdata));
    function automatic logic [31:0] src(input logic [4:0] r);
        return {3'h0, r, 8'hC3, 3'h0, ~r, 8'h5A};
    endfunction
    function automatic logic [31:0] be(input logic [31:0] a, input int n);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < 4; i++)
            v = {v[23:0], i < n ? u_mem.rd8(a + i) : 8'h00};
        return v;
    endfunction
    assign gpr_rd_data = gpr_rd_en ? src(gpr_rd_index) : 32'h5AA5A55A;
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        if (mem_valid && mem_done)
            mq.push_back(mem);
        if (wb_valid)
            wq.push_back(wb);
        if (done)
        begin
            got_done = 1'b1;
            last_exc = exc;
        end
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic chk_wb(input int k, input logic fd, input logic [4:0] idx, input logic [63:0] v);
        check(wq[k].float_dest, fd);
        check(wq[k].index, idx);
        check(fd ? wq[k].value : {32'h0, wq[k].value[31:0]}, v);
    endtask
    task automatic run(input sfl_pkg::sfl_req_t r, input sfl_pkg::sfl_exc_t ex, input int nm, input int nw);
        int n;
        n = 0;
        mq.delete();
        wq.delete();
        got_done = 1'b0;
        req = r;
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1 req_valid = 1'b0;
        while (!got_done && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        #1 check(n < 400, 1'b1);
        check(last_exc, ex);
        check(mq.size(), nm);
        check(wq.size(), nw);
    endtask
    task automatic t_str_load();
        sfl_pkg::sfl_req_t r;
        r = '0;
        r.target_register = 5'h1F;
        r.base_register = 5'h02;
        r.base_value = 32'h00001003;
        r.byte_count_field = 7'h06;
        slow = 1'b1;
        run(r, sfl_pkg::SFL_EXC_NONE, 6, 2);
        slow = 1'b0;
        chk_wb(0, 1'b0, 5'h1F, be(32'h1003, 4));
        chk_wb(1, 1'b0, 5'h00, be(32'h1007, 2));
    endtask
    task automatic t_str_store();
        sfl_pkg::sfl_req_t r;
        logic [31:0] w;
        r = '0;
        r.op = sfl_pkg::SFL_OP_STR_STORE;
        r.target_register = 5'h1E;
        r.base_register = 5'h02;
        r.base_value = 32'h00001101;
        r.byte_count_field = 7'h09;
        run(r, sfl_pkg::SFL_EXC_NONE, 9, 0);
        for (int i = 0; i < 9; i++)
        begin
            w = src(5'(30 + i / 4));
            check({mq[i].write, mq[i].effective_address}, {1'b1, 32'h1101 + i});
            check(mq[i].wdata[7:0], w[31 - 8 * (i % 4) -: 8]);
        end
    endtask
    task automatic t_le();
        sfl_pkg::sfl_req_t r;
        r = '0;
        r.byte_count_field = 7'h04;
        r.base_register = 5'h01;
        r.base_value = 32'h00001000;
        little_endian = 1'b1;
        run(r, sfl_pkg::SFL_EXC_ALIGN, 0, 0);
        r.op = sfl_pkg::SFL_OP_STR_STORE;
        run(r, sfl_pkg::SFL_EXC_ALIGN, 0, 0);
        little_endian = 1'b0;
    endtask
    task automatic t_page();
        sfl_pkg::sfl_req_t r;
        r = '0;
        r.target_register = 5'h08;
        r.base_register = 5'h01;
        r.base_value = 32'h00001FFE;
        r.byte_count_field = 7'h06;
        fault_page = 32'h00002000;
        run(r, sfl_pkg::SFL_EXC_STORAGE, 2, 0);
        foreach (mq[i])
            check(mq[i].effective_address[31:12], 20'h00001);
        check(mq.size() <= 2, 1'b1);
        fault_page = '0;
        run(r, sfl_pkg::SFL_EXC_NONE, 6, 2);
        chk_wb(0, 1'b0, 5'h08, be(32'h1FFE, 4));
        chk_wb(1, 1'b0, 5'h09, be(32'h2002, 2));
    endtask
    task automatic t_forms();
        sfl_pkg::sfl_req_t r;
        r = '0;
        r.target_register = 5'h03;
        r.base_register = 5'h04;
        r.base_value = 32'h00004000;
        r.byte_count_field = 7'h00;
        run(r, sfl_pkg::SFL_EXC_NONE, 32, 8);
        r.indexed = 1'b1;
        r.base_register = 5'h09;
        r.index_register = 5'h03;
        r.xer_count = 7'h08;
        run(r, sfl_pkg::SFL_EXC_NONE, 8, 2);
        r.xer_count = 7'h00;
        run(r, sfl_pkg::SFL_EXC_NONE, 0, 0);
        r.op = sfl_pkg::SFL_OP_STR_STORE;
        run(r, sfl_pkg::SFL_EXC_NONE, 0, 0);
    endtask
    task automatic t_fp();
        sfl_pkg::sfl_req_t r;
        for (int i = 0; i < 4; i++)
            u_mem.mem_b[32'h2FFC + i] = 8'(32'h3F800000 >> (24 - 8 * i));
        r = '0;
        r.op = sfl_pkg::SFL_OP_FP_LOAD;
        r.single = 1'b1;
        r.update = 1'b1;
        r.target_register = 5'h02;
        r.base_register = 5'h05;
        r.base_value = 32'h00003000;
        r.displacement = 16'hFFFC;
        run(r, sfl_pkg::SFL_EXC_NONE, 1, 2);
        chk_wb(0, 1'b1, 5'h02, 64'h3FF0000000000000);
        chk_wb(1, 1'b0, 5'h05, 64'h2FFC);
        r = '0;
        r.op = sfl_pkg::SFL_OP_FP_LOAD;
        r.update = 1'b1;
        r.indexed = 1'b1;
        r.target_register = 5'h06;
        r.index_value = 32'h00003010;
        run(r, sfl_pkg::SFL_EXC_NONE, 1, 1);
        check(mq[0].size_m1, 3'h7);
        chk_wb(0, 1'b1, 5'h06, {be(32'h3010, 4), be(32'h3014, 4)});
        r = '0;
        r.op = sfl_pkg::SFL_OP_FP_STORE;
        r.single = 1'b1;
        r.update = 1'b1;
        r.base_register = 5'h07;
        r.base_value = 32'h00003100;
        r.displacement = 16'h0008;
        r.float_value = 64'hC008000000000000;
        run(r, sfl_pkg::SFL_EXC_NONE, 1, 1);
        check({mq[0].write, mq[0].effective_address, mq[0].size_m1}, {1'b1, 32'h3108, 3'h3});
        check(mq[0].wdata[31:0], 32'hC0400000);
        chk_wb(0, 1'b0, 5'h07, 64'h3108);
        r.op = sfl_pkg::SFL_OP_FP_STORE_INT;
        r.update = 1'b0;
        r.indexed = 1'b1;
        r.index_value = 32'h00000100;
        r.float_value = 64'h1122334455667788;
        run(r, sfl_pkg::SFL_EXC_NONE, 1, 0);
        check({mq[0].effective_address, mq[0].size_m1, mq[0].wdata[31:0]}, {32'h3200, 3'h3, 32'h55667788});
        r = '0;
        r.op = sfl_pkg::SFL_OP_FP_STORE;
        r.update = 1'b1;
        r.displacement = 16'h3300;
        r.float_value = 64'h0123456789ABCDEF;
        run(r, sfl_pkg::SFL_EXC_NONE, 1, 0);
        check({mq[0].size_m1, mq[0].wdata}, {3'h7, 64'h0123456789ABCDEF});
        ds_page = 32'h00003000;
        run(r, sfl_pkg::SFL_EXC_STORAGE, 0, 0);
        ds_page = '0;
        float_unit = 1'b0;
        run(r, sfl_pkg::SFL_EXC_ILLEGAL, 0, 0);
        float_unit = 1'b1;
    endtask
    task automatic close_out();
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_str_load();
        t_str_store();
        t_le();
        t_page();
        t_forms();
        t_fp();
        close_out();
    end
endmodule
